// ==== common/acs_regs.svh ====
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
// ----------------------------------------
// Sequencer constants
// ----------------------------------------
`define ACS_PRIME_CONV 3'd3
`define ACS_VALID_CONV 3'd4
`define ACS_MODE_SINGLE 2'h0
`define ACS_MODE_CONT 2'h1
`define ACS_MODE_MULTI 2'h2
`define ACS_DATA_W 16
`endif

// ==== common/acs_pkg.sv ====
`default_nettype none
package acs_pkg;
    typedef logic [1:0] acs_mode_t;
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_PRIME = 2'b01,
        ACS_RUN = 2'b10
    } acs_state_t;
endpackage
`default_nettype wire

// ==== src/acs_seq.sv ====
`include "acs_regs.svh"
`default_nettype none
module acs_seq (
    input wire logic clock,
    input wire logic rst,
    input wire logic start_bit,
    input wire logic soc_trigger,
    input wire acs_pkg::acs_mode_t mode_sel,
    input wire logic stop,
    input wire logic conv_done,
    input wire logic [`ACS_DATA_W-1:0] conv_data,
    input wire logic mux_switch,
    input wire logic result_read,
    output logic conv_start,
    output logic decim_reset,
    output logic eoc,
    output logic status_done,
    output logic result_valid,
    output logic [`ACS_DATA_W-1:0] result,
    output logic busy
);
    import acs_pkg::*;

    acs_state_t state;
    acs_mode_t mode;
    logic [2:0] conv_cnt;
    logic [2:0] since_switch;
    logic start_evt;
    logic last_conv;
    logic deliver;

    // ----------------------------------------
    // Start and delivery decode
    // ----------------------------------------
    // Either source starts; trigger may stay low in continuous
    assign start_evt = start_bit | soc_trigger;
    // Priming needs three conversions, the fourth is the result
    assign last_conv = (conv_cnt == `ACS_PRIME_CONV);
    assign deliver = conv_done & ((state == ACS_RUN) | ((state == ACS_PRIME) & last_conv));

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Mode latched only at start so mid-run changes wait
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ACS_IDLE;
            mode <= `ACS_MODE_SINGLE;
            conv_cnt <= 3'd0;
            conv_start <= 1'b0;
            decim_reset <= 1'b0;
            busy <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            decim_reset <= 1'b0;
            case (state)
                ACS_IDLE: begin
                    if (start_evt) begin
                        mode <= mode_sel;
                        state <= ACS_PRIME;
                        conv_cnt <= 3'd0;
                        decim_reset <= 1'b1;
                        conv_start <= 1'b1;
                        busy <= 1'b1;
                    end
                end
                ACS_PRIME: begin
                    if (stop) begin
                        state <= ACS_IDLE;
                        busy <= 1'b0;
                    end else if (conv_done) begin
                        if (!last_conv) begin
                            conv_cnt <= conv_cnt + 3'd1;
                            conv_start <= 1'b1;
                        end else if (mode == `ACS_MODE_CONT) begin
                            state <= ACS_RUN;
                            conv_start <= 1'b1;
                        end else if (mode == `ACS_MODE_MULTI) begin
                            // Fresh decimator so older samples leave no trace
                            conv_cnt <= 3'd0;
                            decim_reset <= 1'b1;
                            conv_start <= 1'b1;
                        end else begin
                            state <= ACS_IDLE;
                            busy <= 1'b0;
                        end
                    end
                end
                ACS_RUN: begin
                    if (stop) begin
                        state <= ACS_IDLE;
                        busy <= 1'b0;
                    end else if (conv_done) begin
                        conv_start <= 1'b1;
                    end
                end
                default: begin
                    state <= ACS_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Input switch tracking
    // ----------------------------------------
    // Saturates at four; counts conversions since the last switch
    always_ff @(posedge clock) begin
        if (rst) begin
            since_switch <= 3'd0;
        end else if (mux_switch) begin
            since_switch <= 3'd0;
        end else if (conv_done && since_switch != `ACS_VALID_CONV) begin
            since_switch <= since_switch + 3'd1;
        end
    end

    // ----------------------------------------
    // Result, status and end of conversion
    // ----------------------------------------
    // New completion wins over a read in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            eoc <= 1'b0;
            status_done <= 1'b0;
            result <= '0;
            result_valid <= 1'b0;
        end else if (deliver) begin
            result <= conv_data;
            eoc <= 1'b1;
            status_done <= 1'b1;
            // Valid once the fourth post-switch conversion lands
            result_valid <= (since_switch >= (`ACS_VALID_CONV - 3'd1)) && !mux_switch;
        end else if (result_read) begin
            eoc <= 1'b0;
            status_done <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // End of conversion and status follow every delivered result
    a_eoc_on_done: assert property (@(posedge clock) disable iff (rst)
        deliver |=> eoc && status_done) else $error("eoc not raised");
    // Held until the host reads; a read alone clears it
    a_eoc_holds: assert property (@(posedge clock) disable iff (rst)
        eoc && !result_read |=> eoc) else $error("eoc dropped early");
    a_eoc_clear: assert property (@(posedge clock) disable iff (rst)
        eoc && result_read && !deliver |=> !eoc) else $error("eoc not cleared");
    // Result word only moves when a new one is delivered
    a_result_hold: assert property (@(posedge clock) disable iff (rst)
        !deliver |=> $stable(result)) else $error("result changed without delivery");
    // Any start source kicks off a primed sequence
    a_start_kick: assert property (@(posedge clock) disable iff (rst)
        state == ACS_IDLE && start_evt |=> conv_start && decim_reset && busy)
        else $error("start ignored");
    // Standby stays quiet until a start arrives
    a_idle_quiet: assert property (@(posedge clock) disable iff (rst)
        state == ACS_IDLE && !start_evt |=> !conv_start && !busy)
        else $error("activity while idle");
    a_busy_state: assert property (@(posedge clock) disable iff (rst)
        busy == (state != ACS_IDLE)) else $error("busy disagrees with state");
    // Stop drops back to standby in one edge
    a_stop_idle: assert property (@(posedge clock) disable iff (rst)
        state != ACS_IDLE && stop |=> state == ACS_IDLE && !busy)
        else $error("stop ignored");
    // Mode is frozen for the whole sequence
    a_mode_hold: assert property (@(posedge clock) disable iff (rst)
        state != ACS_IDLE |=> $stable(mode)) else $error("mode changed mid run");

    // ----------------------------------------
    // Sequencing checks
    // ----------------------------------------
    // No result while the decimator is still filling
    a_prime_gap: assert property (@(posedge clock) disable iff (rst)
        state == ACS_PRIME && conv_cnt < `ACS_PRIME_CONV |-> !deliver)
        else $error("result during priming");
    // Continuous keeps converting and never re-primes
    a_cont_run: assert property (@(posedge clock) disable iff (rst)
        state == ACS_RUN && conv_done && !stop |=> conv_start && eoc)
        else $error("continuous stalled");
    a_run_no_reset: assert property (@(posedge clock) disable iff (rst)
        state == ACS_RUN |=> !decim_reset) else $error("continuous re-primed");
    // Multi restarts from a fresh decimator after each result
    a_multi_reprime: assert property (@(posedge clock) disable iff (rst)
        state == ACS_PRIME && mode == `ACS_MODE_MULTI && last_conv && conv_done && !stop
        |=> decim_reset && conv_start && conv_cnt == 3'd0)
        else $error("multi not reprimed");
    a_dec_with_start: assert property (@(posedge clock) disable iff (rst)
        decim_reset |-> conv_start) else $error("reset without conversion");
    a_multi_stay: assert property (@(posedge clock) disable iff (rst)
        state == ACS_PRIME && mode == `ACS_MODE_MULTI && !stop |=> state == ACS_PRIME)
        else $error("multi stopped by itself");
    a_single_idle: assert property (@(posedge clock) disable iff (rst)
        state == ACS_PRIME && mode == `ACS_MODE_SINGLE && last_conv && conv_done && !stop
        |=> state == ACS_IDLE && !busy) else $error("single not idle");
    // Too few conversions since the last switch: result flagged invalid
    a_switch_inv: assert property (@(posedge clock) disable iff (rst)
        deliver && (mux_switch || since_switch < (`ACS_VALID_CONV - 3'd1)) |=> !result_valid)
        else $error("valid right after switch");
    a_valid_set: assert property (@(posedge clock) disable iff (rst)
        deliver && !mux_switch && since_switch == `ACS_VALID_CONV |=> result_valid)
        else $error("settled result not valid");
endmodule
`default_nettype wire

// ==== tb/acs_conv_model.sv ====
`include "acs_regs.svh"
`default_nettype none
// ----------------
// Converter model
// ----------------
module acs_conv_model #(
    parameter int LAT = 3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic conv_start,
    output var logic conv_done,
    output var logic [`ACS_DATA_W-1:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;
    logic [`ACS_DATA_W-1:0] seq;
    // One word per start; data toggles between words so stale values never pass
    always @(negedge clock) begin
        if (rst) begin
            conv_done <= 1'b0;
            wait_cnt <= 4'h0;
            seq <= '0;
            conv_data <= '1;
        end else if (conv_start) begin
            conv_done <= 1'b0;
            wait_cnt <= 4'(LAT);
        end else if (wait_cnt == 4'h1) begin
            seq <= seq + 1'b1;
            conv_done <= 1'b1;
            conv_data <= seq + 1'b1;
            wait_cnt <= 4'h0;
        end else begin
            conv_done <= 1'b0;
            if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
            conv_data <= ~conv_data;
        end
    end
endmodule
`default_nettype wire

// ==== tb/adc_conversion_sequencer_test.sv ====
`include "acs_regs.svh"
`default_nettype none
// ----------------
// Sequencer bench
// ----------------
module adc_conversion_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1, start_bit = 0, soc_trigger = 0, stop = 0;
    logic mux_switch = 0, result_read = 0;
    acs_pkg::acs_mode_t mode_sel = '0;
    logic conv_done, conv_start, decim_reset, eoc, status_done, result_valid, busy;
    logic [`ACS_DATA_W-1:0] conv_data, result, last_data;
    int n_errors = 0, checks = 0, n_done = 0, n_dr = 0, cycles = 0;
    always #5 clock = ~clock;
    acs_seq uut (.clock(clock), .rst(rst), .start_bit(start_bit), .soc_trigger(soc_trigger),
        .mode_sel(mode_sel), .stop(stop), .conv_done(conv_done), .conv_data(conv_data),
        .mux_switch(mux_switch), .result_read(result_read), .conv_start(conv_start),
        .decim_reset(decim_reset), .eoc(eoc), .status_done(status_done),
        .result_valid(result_valid), .result(result), .busy(busy));
    acs_conv_model model (.clock(clock), .rst(rst), .conv_start(conv_start),
        .conv_done(conv_done), .conv_data(conv_data));
    task end_sim;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Count conversions and decimator resets; cap the run against hangs
    always @(posedge clock) begin
        cycles++;
        if (conv_done === 1'b1) begin n_done++; last_data = conv_data; end
        if (decim_reset === 1'b1) n_dr++;
        if (cycles == 3000) begin n_errors++; end_sim(); end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin n_errors++; $display("Error %0t got %h exp %h", $time, got, exp); end
    endtask
    task chk_bit(input logic got, input logic exp);
        chk({15'h0, got}, {15'h0, exp});
    endtask
    task start(input logic trig, input acs_pkg::acs_mode_t m);
        mode_sel = m;
        if (trig) soc_trigger = 1; else start_bit = 1;
        n_done = 0;
        n_dr = 0;
        @(negedge clock);
        soc_trigger = 0;
        start_bit = 0;
    endtask
    task wait_eoc;
        for (int i = 0; i < 200 && eoc !== 1'b1; i++) @(negedge clock);
        chk_bit(eoc, 1'b1);
    endtask
    task read_clr;
        result_read = 1;
        @(negedge clock);
        result_read = 0;
        n_done = 0;
        n_dr = 0;
    endtask
    task switch_input;
        mux_switch = 1;
        @(negedge clock);
        mux_switch = 0;
    endtask
    task halt;
        stop = 1;
        result_read = 1;
        @(negedge clock);
        stop = 0;
        result_read = 0;
        @(negedge clock);
        chk_bit(busy, 1'b0);
        chk_bit(eoc, 1'b0);
    endtask
    // Main sequence: single, continuous with late mode change, multi
    initial begin
        repeat (5) @(negedge clock);
        rst = 0;
        start(1'b0, `ACS_MODE_SINGLE);
        wait_eoc();
        chk(result, last_data);
        chk_bit(status_done, 1'b1);
        repeat (3) @(negedge clock);
        chk(16'(n_done), 16'h4);
        chk_bit(eoc, 1'b1);
        chk_bit(busy, 1'b0);
        read_clr();
        chk_bit(eoc, 1'b0);
        start(1'b1, `ACS_MODE_SINGLE);
        wait_eoc();
        chk(16'(n_done), 16'h4);
        chk(result, last_data);
        read_clr();
        $display("single test over");
        start(1'b1, `ACS_MODE_CONT);
        mode_sel = `ACS_MODE_MULTI;
        wait_eoc();
        chk(16'(n_done), 16'h4);
        read_clr();
        wait_eoc();
        chk(16'(n_done), 16'h1);
        chk(16'(n_dr), 16'h0);
        chk(result, last_data);
        halt();
        $display("continuous test over");
        start(1'b0, `ACS_MODE_MULTI);
        wait_eoc();
        chk_bit(result_valid, 1'b1);
        read_clr();
        repeat (4) @(negedge clock);
        switch_input();
        wait_eoc();
        @(negedge clock);
        chk(16'(n_done), 16'h4);
        chk(16'(n_dr), 16'h1);
        chk_bit(result_valid, 1'b0);
        read_clr();
        wait_eoc();
        chk_bit(result_valid, 1'b1);
        halt();
        $display("multi test over");
        end_sim();
    end
endmodule
`default_nettype wire
